/* logic/wko_regs.svh */
/*
  Register offsets, field positions, reset values and bus answer codes
  of the wake and offload control block.
  Assumes word-aligned 32-bit AXI4-Lite access and a 12-bit byte address.
*/
`ifndef WKO_REGS_SVH
`define WKO_REGS_SVH

// address width and register offsets
`define WKO_AW           12
`define WKO_CTRL_OFS     12'h600
`define WKO_IRQ_STS_OFS  12'h604
`define WKO_IRQ_MSK_OFS  12'h608

// control word reset value and writable bits
`define WKO_CTRL_RST     32'h0000_0000
`define WKO_RW_MASK      32'h8000_070F

// control word field positions
`define WKO_CSUM_OFF_BIT 31
`define WKO_FWD_ARP_BIT  10
`define WKO_FWD_NS_BIT   9
`define WKO_ADV_SEL_BIT  8
`define WKO_FLAG_LSB     4
`define WKO_NS_EN_BIT    3
`define WKO_ARP_EN_BIT   2
`define WKO_V6_EN_BIT    1
`define WKO_V4_EN_BIT    0

// frame class index, same order as the received flags
`define WKO_IDX_V4       0
`define WKO_IDX_V6       1
`define WKO_IDX_ARP      2
`define WKO_IDX_NS       3

// bus answers
`define WKO_RESP_OKAY    2'h0
`define WKO_RESP_SLVERR  2'h2

`endif

/* logic/wko_pkg.sv */
/*
  Types shared by the wake and offload control block: bus carriers,
  the per-frame check report and the main state record.
  Assumes wko_regs.svh on the include path.
*/
`include "wko_regs.svh"

package wko_pkg;

  // one frame class report from a parser, done is a one-cycle pulse
  typedef struct packed {
    logic done;
    logic fcs_ok;
    logic ip_ok;
    logic l4_ok;
  } wko_frame_s;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic                 awvalid;
    logic [`WKO_AW-1:0]   awaddr;
    logic                 wvalid;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bready;
    logic                 arvalid;
    logic [`WKO_AW-1:0]   araddr;
    logic                 rready;
  } wko_axi_req_s;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wko_axi_rsp_s;

  // state of the control block, apart from the received and interrupt flags in wko_sticky
  typedef struct packed {
    wko_axi_rsp_s       axi;
    logic               aw_have;
    logic [`WKO_AW-1:0] awaddr;
    logic               w_have;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic [31:0]        ctrl;
    logic [3:0]         irq_mask;
    logic               ans_ns;
    logic               ans_arp;
    logic               wake_v6;
    logic               wake_v4;
    logic [1:0]         pass;
    logic [1:0]         sink;
    logic [127:0]       na_src;
    logic               irq;
  } wko_state_s;

endpackage : wko_pkg

/* logic/wko_sticky.sv */
/*
  Row of sticky flags: a set pulse raises a flag, a clear pulse drops it.
  Assumes set and clear are synchronous to clk_sys.
*/
`timescale 1ns/10ps

module wko_sticky #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // events
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic [W-1:0]      flag_q
);

  logic [W-1:0] flag_d;

  // set beats a clear in the same cycle, so no event is lost
  always_comb begin
    flag_d = (flag_q & ~clr) | set;
  end

  // flag register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : wko_sticky

/* logic/wko_frame_gate.sv */
/*
  Frame qualifier for one frame class: decides whether a finished frame
  counts for detection, given its check results and the checksum mode.
  Assumes the parser reports ip_ok and l4_ok high where a check does not apply.
*/
`timescale 1ns/10ps

module wko_frame_gate import wko_pkg::*; (
  // frame report
  input  wko_frame_s frame,
  input  wire logic  csum_off,
  // qualified frame, one-cycle pulse
  output logic       valid
);

  logic csum_good;

  // relaxed mode ignores ip, icmp and tcp checksum mismatches
  assign csum_good = csum_off | (frame.ip_ok & frame.l4_ok);
  assign valid     = frame.done & frame.fcs_ok & csum_good;

endmodule : wko_frame_gate

/* logic/wko_ctrl.sv */
/*
  Wake and offload control and status register with its AXI4-Lite slave,
  received-frame flags, interrupt status and mask, and the decisions that
  the parsers, reply generator and resume sequencer act on.
  Assumes all inputs synchronous to clk_sys and parser pulses one cycle long.
*/
// Implementation choice: the AXI4-Lite slave port.
// Contract
// - checksum checking on: ip, tcp and fcs must all pass before detection
// - checksum checking off: only fcs is checked for arp, syn and solicit frames
// - forward bit decides whether offloaded arp frames pass or are sunk
// - forward bit decides whether offloaded solicit frames pass or are sunk
// - advert source is programmed solicit address if select set, else target
// - valid solicit frame sets its received flag until software clears it
// - valid arp frame sets its received flag until software clears it
// - valid ipv6 syn frame sets its flag, software may clear it
// - valid ipv4 syn frame sets its flag, software may clear it
// - resume end clears both syn flags when flag clearing is requested
// - solicit frames are answered only while solicit offload is enabled
// - arp frames are answered only while arp offload is enabled
// - ipv6 syn wakes only while its wake enable is set
// - ipv4 syn wakes only while its wake enable is set
// - resume end clears both syn wake enables when requested
`timescale 1ns/10ps
`include "wko_regs.svh"

module wko_ctrl import wko_pkg::*; (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // register bus
  input  wko_axi_req_s    axi_req,
  output wko_axi_rsp_s    axi_rsp,
  // frame reports, indexed v4 syn, v6 syn, arp, solicit
  input  wko_frame_s [3:0] rx_frame,
  // address sources for the advert reply
  input  wire logic [127:0] solicit_dest_address,
  input  wire logic [127:0] ns_target_address,
  // resume sequencer
  input  wire logic       resume_done,
  input  wire logic       resume_clears_wake_flags,
  input  wire logic       resume_clears_wake_enables,
  // configuration levels
  output logic            checksum_check_off,
  output logic            solicit_offload_enable,
  output logic            arp_offload_enable,
  output logic            v6_syn_wake_enable,
  output logic            v4_syn_wake_enable,
  output logic [127:0]    advert_source_address,
  // decisions, one-cycle pulses
  output logic            answer_solicit,
  output logic            answer_arp,
  output logic            wake_v6_syn,
  output logic            wake_v4_syn,
  output logic [1:0]      frame_pass,
  output logic [1:0]      frame_sink,
  // interrupt
  output logic            irq
);

  wko_state_s  st_q;
  wko_state_s  st_d;
  logic [3:0]  rx_ok;
  logic [3:0]  flag_q;
  logic [3:0]  flag_clr;
  logic [3:0]  irqs_q;
  logic [3:0]  irqs_clr;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  logic        wr_fire;
  logic        wr_ctrl;
  logic        wr_irqs;
  logic        resume_flags;
  logic        resume_enables;
  logic [`WKO_AW-1:0] wr_word_addr;
  logic [`WKO_AW-1:0] rd_word_addr;

  // one qualifier per frame class
  for (genvar i = 0; i < 4; i++) begin : g_gate
    wko_frame_gate u_gate (
      .frame    (rx_frame[i]),
      .csum_off (st_q.ctrl[`WKO_CSUM_OFF_BIT]),
      .valid    (rx_ok[i])
    );
  end

  // write decode; a write completes one cycle after both halves are held
  assign wr_fire      = st_q.aw_have & st_q.w_have & ~st_q.axi.bvalid;
  assign wr_word_addr = {st_q.awaddr[`WKO_AW-1:2], 2'h0};
  assign rd_word_addr = {axi_req.araddr[`WKO_AW-1:2], 2'h0};
  assign wr_ctrl      = wr_fire & (wr_word_addr == `WKO_CTRL_OFS);
  assign wr_irqs      = wr_fire & (wr_word_addr == `WKO_IRQ_STS_OFS);
  assign wmask        = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
  assign wbits        = st_q.wdata & wmask;

  // resume controls only act on the resume end pulse
  assign resume_flags   = resume_done & resume_clears_wake_flags;
  assign resume_enables = resume_done & resume_clears_wake_enables;

  // received flags: write one to clear, resume end drops the syn pair
  always_comb begin
    flag_clr = 4'h0;
    if (wr_ctrl) begin
      flag_clr = wbits[`WKO_FLAG_LSB +: 4];
    end
    if (resume_flags) begin
      flag_clr[`WKO_IDX_V4] = 1'b1;
      flag_clr[`WKO_IDX_V6] = 1'b1;
    end
  end

  // flags set by qualified frames whatever the enables say
  wko_sticky #(.W(4)) u_flags (
    .clk_sys (clk_sys),
    .rst     (rst),
    .set     (rx_ok),
    .clr     (flag_clr),
    .flag_q  (flag_q)
  );

  // interrupt status, same bit layout as the received flags
  assign irqs_clr = wr_irqs ? wbits[`WKO_FLAG_LSB +: 4] : 4'h0;

  wko_sticky #(.W(4)) u_irqs (
    .clk_sys (clk_sys),
    .rst     (rst),
    .set     (rx_ok),
    .clr     (irqs_clr),
    .flag_q  (irqs_q)
  );

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = `WKO_RESP_OKAY;
    case (rd_word_addr)
      `WKO_CTRL_OFS: begin
        rd_word = (st_q.ctrl & `WKO_RW_MASK) | {24'h00_0000, flag_q, 4'h0};
      end
      `WKO_IRQ_STS_OFS: begin
        rd_word = {24'h00_0000, irqs_q, 4'h0};
      end
      `WKO_IRQ_MSK_OFS: begin
        rd_word = {24'h00_0000, st_q.irq_mask, 4'h0};
      end
      default: begin
        rd_resp = `WKO_RESP_SLVERR;
      end
    endcase
  end

  // next state
  always_comb begin
    st_d = st_q;

    // address and data halves are taken in either order
    if (axi_req.awvalid & st_q.axi.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid & st_q.axi.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = axi_req.wdata;
      st_d.wstrb  = axi_req.wstrb;
    end
    if (st_q.axi.bvalid & axi_req.bready) begin
      st_d.axi.bvalid = 1'b0;
    end

    // register write, byte lanes honoured
    if (wr_fire) begin
      st_d.aw_have    = 1'b0;
      st_d.w_have     = 1'b0;
      st_d.axi.bvalid = 1'b1;
      st_d.axi.bresp  = `WKO_RESP_OKAY;
      case (wr_word_addr)
        `WKO_CTRL_OFS: begin
          st_d.ctrl = (st_q.ctrl & ~(wmask & `WKO_RW_MASK)) | (wbits & `WKO_RW_MASK);
        end
        `WKO_IRQ_STS_OFS: begin
          st_d.ctrl = st_q.ctrl; // clearing done in the status flags
        end
        `WKO_IRQ_MSK_OFS: begin
          st_d.irq_mask = (st_q.irq_mask & ~wmask[`WKO_FLAG_LSB +: 4]) | wbits[`WKO_FLAG_LSB +: 4];
        end
        default: begin
          st_d.axi.bresp = `WKO_RESP_SLVERR;
        end
      endcase
    end

    // resume end beats a software write landing in the same cycle
    if (resume_enables) begin
      st_d.ctrl[`WKO_V6_EN_BIT] = 1'b0;
      st_d.ctrl[`WKO_V4_EN_BIT] = 1'b0;
    end

    // hold off new writes until the held one is answered
    st_d.axi.awready = ~st_d.aw_have & ~st_d.axi.bvalid;
    st_d.axi.wready  = ~st_d.w_have & ~st_d.axi.bvalid;

    // reads answer straight from the mux, no read side effects
    if (st_q.axi.rvalid & axi_req.rready) begin
      st_d.axi.rvalid = 1'b0;
    end
    if (axi_req.arvalid & st_q.axi.arready) begin
      st_d.axi.rvalid = 1'b1;
      st_d.axi.rdata  = rd_word;
      st_d.axi.rresp  = rd_resp;
    end
    st_d.axi.arready = ~st_d.axi.rvalid;

    // answer and wake decisions for qualified frames
    st_d.ans_ns  = rx_ok[`WKO_IDX_NS] & st_q.ctrl[`WKO_NS_EN_BIT];
    st_d.ans_arp = rx_ok[`WKO_IDX_ARP] & st_q.ctrl[`WKO_ARP_EN_BIT];
    st_d.wake_v6 = rx_ok[`WKO_IDX_V6] & st_q.ctrl[`WKO_V6_EN_BIT];
    st_d.wake_v4 = rx_ok[`WKO_IDX_V4] & st_q.ctrl[`WKO_V4_EN_BIT];

    // fate of offloaded frames, bit 0 arp, bit 1 solicit
    st_d.pass[0] = st_d.ans_arp & st_q.ctrl[`WKO_FWD_ARP_BIT];
    st_d.sink[0] = st_d.ans_arp & ~st_q.ctrl[`WKO_FWD_ARP_BIT];
    st_d.pass[1] = st_d.ans_ns & st_q.ctrl[`WKO_FWD_NS_BIT];
    st_d.sink[1] = st_d.ans_ns & ~st_q.ctrl[`WKO_FWD_NS_BIT];

    // advert source address, registered to keep the output a flop
    st_d.na_src = st_q.ctrl[`WKO_ADV_SEL_BIT] ? solicit_dest_address : ns_target_address;

    // interrupt lags the status by one cycle
    st_d.irq = |(irqs_q & st_q.irq_mask);
  end

  // state register; ready lines come out of reset high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q             <= '0;
      st_q.ctrl        <= `WKO_CTRL_RST;
      st_q.axi.awready <= 1'b1;
      st_q.axi.wready  <= 1'b1;
      st_q.axi.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign axi_rsp                = st_q.axi;
  assign checksum_check_off     = st_q.ctrl[`WKO_CSUM_OFF_BIT];
  assign solicit_offload_enable = st_q.ctrl[`WKO_NS_EN_BIT];
  assign arp_offload_enable     = st_q.ctrl[`WKO_ARP_EN_BIT];
  assign v6_syn_wake_enable     = st_q.ctrl[`WKO_V6_EN_BIT];
  assign v4_syn_wake_enable     = st_q.ctrl[`WKO_V4_EN_BIT];
  assign advert_source_address  = st_q.na_src;
  assign answer_solicit         = st_q.ans_ns;
  assign answer_arp             = st_q.ans_arp;
  assign wake_v6_syn            = st_q.wake_v6;
  assign wake_v4_syn            = st_q.wake_v4;
  assign frame_pass             = st_q.pass;
  assign frame_sink             = st_q.sink;
  assign irq                    = st_q.irq;

endmodule : wko_ctrl

/* verif/wko_ctrl_properties.sv */
/*
  Checker of the wake and offload decisions.
  Assumes binding to wko_ctrl; sees its ports only.
*/
`timescale 1ns/10ps

module wko_ctrl_properties import wko_pkg::*; (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // events
  input wko_frame_s [3:0] rx_frame,
  input wire logic        resume_done,
  input wire logic        resume_clears_wake_enables,
  // levels
  input wire logic        checksum_check_off,
  input wire logic        solicit_offload_enable,
  input wire logic        arp_offload_enable,
  input wire logic        v6_syn_wake_enable,
  input wire logic        v4_syn_wake_enable,
  // decisions
  input wire logic        answer_solicit,
  input wire logic        answer_arp,
  input wire logic        wake_v6_syn,
  input wire logic        wake_v4_syn,
  input wire logic [1:0]  frame_pass,
  input wire logic [1:0]  frame_sink
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // frame report coded {done, fcs, ip, l4}; pulses follow one cycle on
  a_v4_all_ok:
    assert property (rx_frame[0] == 4'hF && v4_syn_wake_enable |=> wake_v4_syn) else $error("v4 wake lost");
  a_csum_skip:
    assert property (rx_frame[0] == 4'hC && checksum_check_off && v4_syn_wake_enable |=> wake_v4_syn)
      else $error("v4 wake lost, checks off");
  a_fcs_bad:
    assert property (rx_frame[0] == 4'hB |=> !wake_v4_syn) else $error("bad fcs woke");
  a_v6_wake:
    assert property (wake_v6_syn |-> $past(v6_syn_wake_enable && rx_frame[1].done)) else $error("v6 wake");
  a_arp_gate:
    assert property (answer_arp |-> $past(arp_offload_enable && rx_frame[2].done)) else $error("arp answer");
  a_ns_gate:
    assert property (answer_solicit |-> $past(solicit_offload_enable && rx_frame[3].done))
      else $error("solicit answer");
  // an answered arp frame is either passed or sunk, never both
  a_arp_fate:
    assert property (answer_arp |-> frame_pass[0] ^ frame_sink[0]) else $error("arp fate");
  a_ns_fate:
    assert property (answer_solicit |-> frame_pass[1] ^ frame_sink[1]) else $error("solicit fate");
  a_resume_en:
    assert property (resume_done && resume_clears_wake_enables |=> !v6_syn_wake_enable && !v4_syn_wake_enable)
      else $error("resume kept enables");
endmodule : wko_ctrl_properties

bind wko_ctrl wko_ctrl_properties u_wko_ctrl_properties (
  .clk_sys, .rst, .rx_frame, .resume_done, .resume_clears_wake_enables, .checksum_check_off,
  .solicit_offload_enable, .arp_offload_enable, .v6_syn_wake_enable, .v4_syn_wake_enable,
  .answer_solicit, .answer_arp, .wake_v6_syn, .wake_v4_syn, .frame_pass, .frame_sink
);

/* verif/wko_ctrl_test.sv */
/*
  Bench of the wake and offload block: bus, frame and resume sequences.
  Assumes wko_ctrl with its checker bound; 100 MHz clock.
*/
`timescale 1ns/10ps

module wko_ctrl_test import wko_pkg::*;;
  // design ports
  logic             clk_sys, rst, resume_done, resume_clears_wake_flags, resume_clears_wake_enables;
  logic [127:0]     solicit_dest_address, ns_target_address, advert_source_address;
  wko_axi_req_s     q;
  wko_axi_rsp_s     p;
  wko_frame_s [3:0] rx_frame;
  logic             checksum_check_off, solicit_offload_enable, arp_offload_enable, irq;
  logic             v6_syn_wake_enable, v4_syn_wake_enable;
  logic             answer_solicit, answer_arp, wake_v6_syn, wake_v4_syn;
  logic [1:0]       frame_pass, frame_sink;
  // bench state
  int               failures, cmp_count;
  logic [31:0]      rd_v;
  logic [1:0]       rs;
  localparam logic [11:0] ctl_a = 12'h600;
  localparam logic [11:0] sts_a = 12'h604;
  localparam logic [11:0] msk_a = 12'h608;

  wko_ctrl u_wko_ctrl (
    .clk_sys, .rst, .axi_req(q), .axi_rsp(p), .rx_frame, .solicit_dest_address, .ns_target_address,
    .resume_done, .resume_clears_wake_flags, .resume_clears_wake_enables, .checksum_check_off,
    .solicit_offload_enable, .arp_offload_enable, .v6_syn_wake_enable, .v4_syn_wake_enable,
    .advert_source_address, .answer_solicit, .answer_arp, .wake_v6_syn, .wake_v4_syn, .frame_pass,
    .frame_sink, .irq
  );

  // 100 MHz clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : ck

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    q.awvalid <= 1'b1;
    q.awaddr  <= a;
    q.wvalid  <= 1'b1;
    q.wdata   <= d;
    q.wstrb   <= 4'hF;
    q.bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (p.awready) q.awvalid <= 1'b0;
      if (p.wready) q.wvalid <= 1'b0;
    end while (!p.bvalid);
    q.bready <= 1'b0;
    rs = p.bresp;
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    q.arvalid <= 1'b1;
    q.araddr  <= a;
    q.rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (p.arready) q.arvalid <= 1'b0;
    end while (!p.rvalid);
    q.rready <= 1'b0;
    rd_v = p.rdata;
    rs = p.rresp;
    ck($sformatf("reg %h", a), e, rd_v);
  endtask : rc

  // one frame report; decisions are looked at in the cycle after done
  task automatic fr(input int i, input logic [2:0] ok, input logic [7:0] e);
    @(posedge clk_sys);
    rx_frame[i] <= {1'b1, ok};
    @(posedge clk_sys);
    rx_frame[i] <= '0;
    #1;
    ck("decisions", 32'(e), 32'({answer_solicit, answer_arp, wake_v6_syn, wake_v4_syn, frame_pass, frame_sink}));
  endtask : fr

  task automatic rsm();
    @(posedge clk_sys);
    resume_done <= 1'b1;
    @(posedge clk_sys);
    resume_done <= 1'b0;
  endtask : rsm

  task automatic complete_run();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // watchdog, far beyond the roughly 120 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    complete_run();
  end

  initial begin
    q = '0;
    rx_frame = '0;
    resume_done = 1'b0;
    resume_clears_wake_flags = 1'b0;
    resume_clears_wake_enables = 1'b0;
    solicit_dest_address = {4{32'hA5A5_0F0F}};
    ns_target_address = {4{32'h3C3C_1234}};
    rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rc(ctl_a, 32'h0);
    rc(sts_a, 32'h0);
    wr(ctl_a, 32'hFFFF_FFFF);
    ck("write resp", 32'h0, 32'(rs));
    rc(ctl_a, 32'h8000_070F);
    wr(12'h700, 32'h1);
    ck("unmapped write", 32'h2, 32'(rs));
    rc(12'h700, 32'h0);
    ck("unmapped read", 32'h2, 32'(rs));
    // checks on, forwarding off
    wr(ctl_a, 32'h0000_000F);
    ck("levels on", 32'h0F, 32'({checksum_check_off, solicit_offload_enable, arp_offload_enable,
      v6_syn_wake_enable, v4_syn_wake_enable}));
    fr(2, 3'b111, 8'h41);
    fr(2, 3'b101, 8'h00);
    fr(0, 3'b110, 8'h00);
    fr(0, 3'b111, 8'h10);
    fr(3, 3'b111, 8'h82);
    // checks off, forwarding on
    wr(ctl_a, 32'h8000_060F);
    ck("levels off", 32'h1F, 32'({checksum_check_off, solicit_offload_enable, arp_offload_enable,
      v6_syn_wake_enable, v4_syn_wake_enable}));
    fr(2, 3'b101, 8'h44);
    fr(3, 3'b100, 8'h88);
    fr(1, 3'b111, 8'h20);
    fr(0, 3'b011, 8'h00);
    fr(0, 3'b100, 8'h10);
    rc(ctl_a, 32'h8000_06FF);
    // interrupt raised by an unmasked flag, dropped by its clear
    rc(sts_a, 32'h0000_00F0);
    wr(msk_a, 32'h0000_0020);
    rc(msk_a, 32'h0000_0020);
    ck("irq set", 32'h1, 32'(irq));
    wr(sts_a, 32'h0000_0020);
    rc(sts_a, 32'h0000_00D0);
    ck("irq clear", 32'h0, 32'(irq));
    wr(ctl_a, 32'h8000_064F);
    rc(ctl_a, 32'h8000_06BF);
    // all enables off: flags still set, nothing answered or woken
    wr(ctl_a, 32'h8000_0600);
    ck("levels idle", 32'h10, 32'({checksum_check_off, solicit_offload_enable, arp_offload_enable,
      v6_syn_wake_enable, v4_syn_wake_enable}));
    fr(2, 3'b111, 8'h00);
    fr(3, 3'b111, 8'h00);
    fr(1, 3'b111, 8'h00);
    fr(0, 3'b111, 8'h00);
    rc(ctl_a, 32'h8000_06F0);
    // resume without, then with, the clearing controls
    wr(ctl_a, 32'h8000_0603);
    rsm();
    rc(ctl_a, 32'h8000_06F3);
    resume_clears_wake_flags <= 1'b1;
    resume_clears_wake_enables <= 1'b1;
    rsm();
    rc(ctl_a, 32'h8000_06C0);
    wr(ctl_a, 32'h0000_0100);
    @(posedge clk_sys);
    ck("advert dest", 32'h1, 32'(advert_source_address === solicit_dest_address));
    wr(ctl_a, 32'h0);
    @(posedge clk_sys);
    ck("advert target", 32'h1, 32'(advert_source_address === ns_target_address));
    complete_run();
  end
endmodule : wko_ctrl_test
